// ===== logic/tldf_pkg.sv
// Constants and rule summary for the debug flag block.
// Assumes a single 10 MHz clock and a synchronous active-high reset.
//
// Function
// - Sampling ready flag while facility prepared
// - Start bit runs; clear suspends, drops flags
// - Running flag while sampling active
// - Trigger bit rise equals trigger instruction
// - After-trigger flag, then done flag
// - Latch ready flag while able to capture
// - Latch command rise takes one capture
// - Latch done flag after capture finishes
// - Latch clear rise re-arms latch
// - Program trace ready flag while prepared
// - Program start runs; clear suspends, drops flags
// - Program running flag while executing
// - Program trigger rise equals trigger instruction
// - Program after-trigger flag, then done flag
// - Step ready after registration and ready
// - Step start runs; clear suspends, drops flags
// - Step running until completion or suspension
// - First-trigger on any block; cleared at start
// - All-triggers when every block; cleared at start
// - Step done at finish; cleared at start
// - Separate error flags for sampling, latch and program trace
`default_nettype none
package tldf_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] TLDF_CTL_OFS  = 4'h0;
  localparam logic [3:0] TLDF_STAT_OFS = 4'h4;
  localparam logic [3:0] TLDF_STEP_OFS = 4'h8;
  // Control field positions
  localparam int TLDF_CTL_SSTART = 0;
  localparam int TLDF_CTL_STRIG  = 1;
  localparam int TLDF_CTL_LCMD   = 2;
  localparam int TLDF_CTL_LCLR   = 3;
  localparam int TLDF_CTL_PSTART = 4;
  localparam int TLDF_CTL_PTRIG  = 5;
  localparam int TLDF_CTL_TSTART = 6;
  localparam logic [6:0] TLDF_CTL_RST = 7'h00;
  // ****************************************************************
  // Facility states
  // ****************************************************************
  typedef enum logic [1:0] {TLDF_IDLE, TLDF_RUN, TLDF_POST, TLDF_DONE} tldf_trace_t;
endpackage
`default_nettype wire

// ===== logic/tldf_trace.sv
// One trace facility: sampling or program trace flags.
// Assumes the start level comes from the control register and the trigger pulse from its trigger bit or the trigger instruction.
`default_nettype none
module tldf_trace
  import tldf_pkg::*;
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  // Control
  input  wire logic i_ready,
  input  wire logic i_start,
  input  wire logic i_trig,
  input  wire logic i_finish,
  input  wire logic i_err,
  // Status
  output logic      o_running,
  output logic      o_after,
  output logic      o_done,
  output logic      o_error
);
  tldf_trace_t state_reg, state_next;
  logic        err_reg,   err_next;

  always_comb begin
    state_next = state_reg;
    err_next   = err_reg;
    if (!i_start) begin
      state_next = TLDF_IDLE;
      err_next   = 1'b0;
    end else begin
      unique case (state_reg)
        TLDF_IDLE: if (i_ready) state_next = TLDF_RUN;
        TLDF_RUN:  if (i_trig) state_next = TLDF_POST;
        TLDF_POST: if (i_finish) state_next = TLDF_DONE;
        TLDF_DONE: state_next = TLDF_DONE;
      endcase
      if (i_err && (state_reg == TLDF_RUN || state_reg == TLDF_POST)) begin
        err_next = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_reg <= TLDF_IDLE;
      err_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      err_reg   <= err_next;
    end
  end

  assign o_running = (state_reg == TLDF_RUN) || (state_reg == TLDF_POST);
  assign o_after   = (state_reg == TLDF_POST) || (state_reg == TLDF_DONE);
  assign o_done    = (state_reg == TLDF_DONE);
  assign o_error   = err_reg;
endmodule
`default_nettype wire

// ===== logic/tldf_top.sv
// Debug flag block: sampling, latch, program and step trace flags.
// Assumes a plain register port; read data appear one cycle after the strobe.
`default_nettype none
module tldf_top
  import tldf_pkg::*;
#(
  parameter int NBLK = 4
)(
  // Clock and reset
  input  wire logic            i_clk,
  input  wire logic            i_sys_rst,
  // Register port
  input  wire logic [3:0]      i_addr,
  input  wire logic [31:0]     i_wdata,
  input  wire logic            i_wr,
  input  wire logic            i_rd,
  output logic      [31:0]     o_rdata,
  // Engine handshakes
  input  wire logic            i_sampling_prepared,
  input  wire logic            i_sampling_trigger_instr,
  input  wire logic            i_sampling_finish,
  input  wire logic            i_sampling_fault,
  input  wire logic            i_latch_prepared,
  input  wire logic            i_latch_finish,
  input  wire logic            i_latch_fault,
  input  wire logic            i_prog_prepared,
  input  wire logic            i_prog_trigger_instr,
  input  wire logic            i_prog_finish,
  input  wire logic            i_prog_fault,
  input  wire logic            i_step_registered,
  input  wire logic [NBLK-1:0] i_step_blk_trig,
  input  wire logic            i_step_finish,
  // Status flags
  output logic                 o_sampling_ready_flag,
  output logic                 o_sampling_running_flag,
  output logic                 o_sampling_done_flag,
  output logic                 o_latch_ready_flag,
  output logic                 o_latch_done_flag,
  output logic                 o_latch_capture,
  output logic                 o_prog_trace_running_flag,
  output logic                 o_step_trace_running_flag,
  output logic                 o_step_trace_done_flag
);
  // ****************************************************************
  // Control register
  // ****************************************************************
  logic [6:0]      ctl_reg,   ctl_next;
  logic [6:0]      ctlq_reg,  ctlq_next;
  logic            lat_busy_reg, lat_busy_next;
  logic            lat_done_reg, lat_done_next;
  logic            lat_err_reg,  lat_err_next;
  logic            cap_reg,   cap_next;
  logic            st_run_reg, st_run_next;
  logic            st_done_reg, st_done_next;
  logic [NBLK-1:0] blk_reg,   blk_next;
  logic [31:0]     rd_reg,    rd_next;
  logic [9:0]      out_reg,   out_next;
  logic            s_rise, l_cmd_rise, l_clr_rise, p_rise, t_start_rise;
  logic            s_run, s_after, s_done, s_err;
  logic            p_run, p_after, p_done, p_err;
  logic            first_trig, all_trig;
  logic            step_ready;

  function automatic logic rise(input logic [6:0] now, input logic [6:0] was, input int b);
    rise = now[b] && !was[b];
  endfunction

  assign s_rise       = rise(ctl_reg, ctlq_reg, TLDF_CTL_STRIG) || i_sampling_trigger_instr;
  assign p_rise       = rise(ctl_reg, ctlq_reg, TLDF_CTL_PTRIG) || i_prog_trigger_instr;
  assign l_cmd_rise   = rise(ctl_reg, ctlq_reg, TLDF_CTL_LCMD);
  assign l_clr_rise   = rise(ctl_reg, ctlq_reg, TLDF_CTL_LCLR);
  assign t_start_rise = rise(ctl_reg, ctlq_reg, TLDF_CTL_TSTART);

  // ****************************************************************
  // Sampling and program trace
  // ****************************************************************
  tldf_trace u_samp (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ready   (i_sampling_prepared),
    .i_start   (ctl_reg[TLDF_CTL_SSTART]),
    .i_trig    (s_rise),
    .i_finish  (i_sampling_finish),
    .i_err     (i_sampling_fault),
    .o_running (s_run),
    .o_after   (s_after),
    .o_done    (s_done),
    .o_error   (s_err)
  );

  tldf_trace u_prog (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_ready   (i_prog_prepared),
    .i_start   (ctl_reg[TLDF_CTL_PSTART]),
    .i_trig    (p_rise),
    .i_finish  (i_prog_finish),
    .i_err     (i_prog_fault),
    .o_running (p_run),
    .o_after   (p_after),
    .o_done    (p_done),
    .o_error   (p_err)
  );

  // ****************************************************************
  // Latch, step trace and register port
  // ****************************************************************
  assign step_ready = i_step_registered && !st_run_reg;
  assign first_trig = |blk_reg;
  assign all_trig   = &blk_reg;

  always_comb begin
    ctl_next      = ctl_reg;
    ctlq_next     = ctl_reg;
    lat_busy_next = lat_busy_reg;
    lat_done_next = lat_done_reg;
    lat_err_next  = lat_err_reg;
    cap_next      = 1'b0;
    st_run_next   = st_run_reg;
    st_done_next  = st_done_reg;
    blk_next      = blk_reg;
    rd_next       = 32'h0000_0000;
    if (i_wr && i_addr == TLDF_CTL_OFS) begin
      ctl_next = i_wdata[6:0];
    end
    // Only one capture per arming; further commands are ignored until a clear
    if (l_cmd_rise && !lat_busy_reg && !lat_done_reg && i_latch_prepared) begin
      lat_busy_next = 1'b1;
      cap_next      = 1'b1;
    end
    if (lat_busy_reg && i_latch_fault) begin
      lat_err_next = 1'b1;
    end
    if (lat_busy_reg && i_latch_finish) begin
      lat_busy_next = 1'b0;
      lat_done_next = 1'b1;
    end
    if (l_clr_rise) begin
      lat_done_next = 1'b0;
      lat_err_next  = 1'b0;
    end
    if (t_start_rise) begin
      st_run_next  = 1'b1;
      st_done_next = 1'b0;
      blk_next     = '0;
    end else if (!ctl_reg[TLDF_CTL_TSTART]) begin
      st_run_next  = 1'b0;
      blk_next     = '0;
      st_done_next = 1'b0;
    end else if (st_run_reg) begin
      blk_next = blk_reg | i_step_blk_trig;
      if (i_step_finish) begin
        st_run_next  = 1'b0;
        st_done_next = 1'b1;
      end
    end
    if (i_rd) begin
      unique case (i_addr)
        TLDF_CTL_OFS:  rd_next = {25'h0, ctl_reg};
        TLDF_STAT_OFS: rd_next = {16'h0, p_err, lat_err_reg, s_err, 1'b0,
                                  p_done, p_after, p_run, i_prog_prepared, lat_done_reg,
                                  i_latch_prepared && !lat_busy_reg && !lat_done_reg,
                                  s_done, s_after, s_run, i_sampling_prepared, 2'h0};
        TLDF_STEP_OFS: rd_next = {27'h0, st_done_reg, all_trig, first_trig,
                                  st_run_reg, step_ready};
        default:       rd_next = 32'h0000_0000;
      endcase
    end
    out_next = {i_sampling_prepared, s_run, s_done,
                i_latch_prepared && !lat_busy_reg && !lat_done_reg, lat_done_reg,
                cap_reg, p_run, st_run_reg, st_done_reg, 1'b0};
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctl_reg      <= TLDF_CTL_RST;
      ctlq_reg     <= TLDF_CTL_RST;
      lat_busy_reg <= 1'b0;
      lat_done_reg <= 1'b0;
      lat_err_reg  <= 1'b0;
      cap_reg      <= 1'b0;
      st_run_reg   <= 1'b0;
      st_done_reg  <= 1'b0;
      blk_reg      <= '0;
      rd_reg       <= 32'h0000_0000;
      out_reg      <= 10'h000;
    end else begin
      ctl_reg      <= ctl_next;
      ctlq_reg     <= ctlq_next;
      lat_busy_reg <= lat_busy_next;
      lat_done_reg <= lat_done_next;
      lat_err_reg  <= lat_err_next;
      cap_reg      <= cap_next;
      st_run_reg   <= st_run_next;
      st_done_reg  <= st_done_next;
      blk_reg      <= blk_next;
      rd_reg       <= rd_next;
      out_reg      <= out_next;
    end
  end

  assign o_rdata                   = rd_reg;
  assign o_sampling_ready_flag     = out_reg[9];
  assign o_sampling_running_flag   = out_reg[8];
  assign o_sampling_done_flag      = out_reg[7];
  assign o_latch_ready_flag        = out_reg[6];
  assign o_latch_done_flag         = out_reg[5];
  assign o_latch_capture           = out_reg[4];
  assign o_prog_trace_running_flag = out_reg[3];
  assign o_step_trace_running_flag = out_reg[2];
  assign o_step_trace_done_flag    = out_reg[1];
endmodule
`default_nettype wire

// ===== tb/tldf_checker.sv
// Port-level assertions for the debug flag block.
// Assumes it is bound into tldf_top and shares its single clock.
`default_nettype none
module tldf_checker #(
  parameter int NBLK = 4
)(
  // Clock, reset and register port
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  // Facility handshakes and flags
  input wire logic        i_sampling_prepared,
  input wire logic        i_latch_prepared,
  input wire logic        o_sampling_ready_flag,
  input wire logic        o_sampling_running_flag,
  input wire logic        o_sampling_done_flag,
  input wire logic        o_latch_ready_flag,
  input wire logic        o_latch_done_flag,
  input wire logic        o_latch_capture,
  input wire logic        o_step_trace_running_flag,
  input wire logic        o_step_trace_done_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  rst_clear_a: assert property (
    i_sys_rst |=> !(o_sampling_ready_flag || o_latch_ready_flag || o_latch_done_flag ||
    o_step_trace_done_flag) && o_rdata == 32'h0) else $error("flags set after reset");
  rdata_idle_a: assert property (disable iff (i_sys_rst)
    !$past(i_rd) |-> o_rdata == 32'h0) else $error("read data without read strobe");
  samp_ready_a: assert property (disable iff (i_sys_rst)
    !i_sampling_prepared [*3] |-> !o_sampling_ready_flag) else $error("sampling ready early");
  latch_ready_a: assert property (disable iff (i_sys_rst)
    !i_latch_prepared [*3] |-> !o_latch_ready_flag) else $error("latch ready early");
  capture_once_a: assert property (disable iff (i_sys_rst)
    o_latch_capture |=> !o_latch_capture) else $error("capture pulse too long");
  capture_gate_a: assert property (disable iff (i_sys_rst)
    o_latch_capture |-> !o_latch_done_flag) else $error("capture while latch done");
  samp_done_a: assert property (disable iff (i_sys_rst)
    $rose(o_sampling_done_flag) |-> !o_sampling_running_flag) else $error("done while running");
  step_done_a: assert property (disable iff (i_sys_rst)
    $rose(o_step_trace_done_flag) |-> !o_step_trace_running_flag) else $error("step done early");
endmodule
bind tldf_top tldf_checker #(.NBLK(NBLK)) i_chk (.*);
`default_nettype wire

// ===== tb/tb_trace_latch_debug_flags.sv
// Self-checking bench for the debug flag block.
// Assumes tldf_top with its plain register port and one 10 MHz clock.
`default_nettype none
module tb_trace_latch_debug_flags;
  import tldf_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        i_clk, i_sys_rst, i_wr, i_rd, i_sampling_prepared, i_latch_prepared;
  logic        i_prog_prepared, i_step_registered;
  logic [3:0]  i_addr, i_step_blk_trig, bt;
  logic [31:0] i_wdata, o_rdata, d, s0;
  logic [8:0]  pk;
  logic        o_sampling_ready_flag, o_sampling_running_flag, o_sampling_done_flag;
  logic        o_latch_ready_flag, o_latch_done_flag, o_latch_capture;
  logic        o_prog_trace_running_flag, o_step_trace_running_flag, o_step_trace_done_flag;
  int          n_fail = 0, checks = 0, ncap = 0, n;
  // Engine pulses share one vector so a single task can strobe any of them
  tldf_top i_dut (.*, .i_sampling_trigger_instr(pk[0]), .i_sampling_finish(pk[1]),
    .i_sampling_fault(pk[2]), .i_latch_finish(pk[3]), .i_latch_fault(pk[4]),
    .i_prog_trigger_instr(pk[5]), .i_prog_finish(pk[6]), .i_prog_fault(pk[7]),
    .i_step_finish(pk[8]));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  always @(posedge i_clk) if (o_latch_capture === 1'b1) ncap++;
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk);
    {i_wr, i_addr, i_wdata} <= {1'b1, a, v};
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    {i_rd, i_addr} <= {1'b1, a};
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask
  task automatic wt();
    repeat (5) @(posedge i_clk);
  endtask
  task automatic pl(input int b);
    @(posedge i_clk);
    pk[b] <= 1'b1;
    @(posedge i_clk);
    pk <= '0;
  endtask
  task automatic blk(input logic [3:0] v);
    @(posedge i_clk);
    i_step_blk_trig <= v;
    @(posedge i_clk);
    i_step_blk_trig <= 4'h0;
  endtask
  // One trace facility: k 0 sampling, 1 program; ins picks the trigger instruction
  task automatic trc(input int k, input int ins);
    int b;
    logic [31:0] s;
    b = k ? 8 : 2;
    s = k ? 32'h10 : 32'h01;
    wr(4'h0, s); wt(); rd(4'h4);
    chk(d[b+:4], 32'h3);
    chk(k ? o_prog_trace_running_flag : o_sampling_running_flag, 32'h1);
    pl(k ? 7 : 2); wt(); rd(4'h4);
    chk(d[k ? 15 : 13], 32'h1);
    if (ins) pl(k ? 5 : 0);
    else wr(4'h0, s | (s << 1));
    wt(); rd(4'h4);
    chk(d[b+:4], 32'h7);
    pl(k ? 6 : 1); wt(); rd(4'h4);
    chk({d[b+3], d[b+1]}, 32'h2);
    wr(4'h0, 32'h0); wt(); rd(4'h4);
    chk({d[k ? 15 : 13], d[b+:4]}, 32'h1);
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {i_sys_rst, i_wr, i_rd, i_sampling_prepared, i_latch_prepared} = 5'h10;
    {i_prog_prepared, i_step_registered, i_addr, i_step_blk_trig, pk} = '0;
    i_wdata = 32'h0;
    void'($urandom(32'hD1C51ECE));
    repeat (3) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd(4'h4);
    chk(d, 32'h0);
    @(posedge i_clk);
    {i_sampling_prepared, i_latch_prepared, i_prog_prepared, i_step_registered} <= 4'hF;
    wt(); rd(4'h4);
    s0 = d;
    chk({s0[8], s0[7:6], s0[2]}, 32'hB);
    repeat (8) begin
      wr($urandom % 2 ? 4'h8 : 4'h4, $urandom);
      rd(4'hC | 4'($urandom % 4));
      chk(d, 32'h0);
    end
    rd(4'h4);
    chk(d, s0);
    n = ncap;
    wr(4'h0, 32'h4); wt();
    chk(ncap - n, 32'h1);
    pl(4); pl(3); wt(); rd(4'h4);
    chk({o_latch_done_flag, d[14], d[7:6]}, 32'hE);
    wr(4'h0, 32'h0); wr(4'h0, 32'h4); wt();
    chk(ncap - n, 32'h1);
    wr(4'h0, 32'h8); wt(); rd(4'h4);
    chk({d[14], d[7:6]}, 32'h1);
    wr(4'h0, 32'h4); wt();
    chk(ncap - n, 32'h2);
    for (int r = 0; r < 4; r++) trc(r % 2, r / 2);
    wr(4'h0, 32'h40); wt(); rd(4'h8);
    chk(d[4:0], 32'h02);
    bt = 4'h1 << ($urandom % 4);
    blk(bt); wt(); rd(4'h8);
    chk(d[4:0], 32'h06);
    blk(~bt); wt(); rd(4'h8);
    chk(d[4:0], 32'h0E);
    pl(8); wt(); rd(4'h8);
    chk({o_step_trace_done_flag, d[4:0]}, 32'h3D);
    wr(4'h0, 32'h0); wr(4'h0, 32'h40); wt(); rd(4'h8);
    chk(d[4:0], 32'h02);
    wr(4'h0, 32'h0); wt(); rd(4'h8);
    chk(d[4:0], 32'h01);
    finish_test();
  end
  // Whole run is well under 1500 cycles; stop a hang at 3000
  initial begin
    #(100 * 3000);
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
